// ==== common/pls_defs.svh ====
// Timing counts, register offsets, field positions and reset values for the LED status driver
`ifndef PLS_DEFS_SVH
`define PLS_DEFS_SVH
`define PLS_BLINK_MS 50
`define PLS_CLK_MHZ 250
`define PLS_BLINK_CYCLES (`PLS_BLINK_MS * 1000 * `PLS_CLK_MHZ)
`define PLS_OFF_CTRL 12'h000
`define PLS_OFF_STATUS 12'h004
`define PLS_CTRL_MODE_LSB 0
`define PLS_CTRL_MODE_MSB 1
`define PLS_CTRL_DUPSEL_BIT 4
`define PLS_CTRL_RESET 32'h0000_0001
`endif

// ==== common/pls_pkg.sv ====
// Types for the LED status driver
package pls_pkg;
  typedef enum logic [1:0] {
    PLS_MODE_RSVD,
    PLS_MODE_1,
    PLS_MODE_2,
    PLS_MODE_3
  } pls_mode_t;
  typedef enum logic [1:0] {
    PLS_BL_IDLE,
    PLS_BL_ON,
    PLS_BL_OFF
  } pls_blink_t;
endpackage : pls_pkg

// ==== src/pls_blinker.sv ====
// Activity stretcher: a visible on/off blink starts whenever activity is seen while idle
`timescale 1ns/100ps
`default_nettype none
module pls_blinker #(
  parameter int unsigned HALF_CYCLES = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Activity in, blink out
  input wire logic act,
  output logic busy,
  output logic dark
);
  pls_pkg::pls_blink_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;

  // Next state: ON phase then OFF phase, each HALF_CYCLES long
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      pls_pkg::PLS_BL_IDLE: begin
        if (act) begin
          st_d = pls_pkg::PLS_BL_ON;
          cnt_d = 32'h0000_0000;
        end
      end
      pls_pkg::PLS_BL_ON: begin
        if (cnt_q == HALF_CYCLES - 1) begin
          st_d = pls_pkg::PLS_BL_OFF;
          cnt_d = 32'h0000_0000;
        end else begin
          cnt_d = cnt_q + 32'h0000_0001;
        end
      end
      default: begin
        if (cnt_q == HALF_CYCLES - 1) begin
          st_d = pls_pkg::PLS_BL_IDLE;
          cnt_d = 32'h0000_0000;
        end else begin
          cnt_d = cnt_q + 32'h0000_0001;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= pls_pkg::PLS_BL_IDLE;
      cnt_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign busy = (st_q != pls_pkg::PLS_BL_IDLE);
  assign dark = (st_q == pls_pkg::PLS_BL_OFF);

  AST_OFF_AFTER_ON: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == pls_pkg::PLS_BL_ON) && (cnt_q == HALF_CYCLES - 1) |=> dark) // [R07]
    else $error("blink off phase did not follow on phase");
endmodule : pls_blinker
`default_nettype wire

// ==== src/pls_led_driver.sv ====
// LED status driver top: pin sync, mode logic, APB registers
`timescale 1ns/100ps
`default_nettype none
`include "pls_defs.svh"
// Functional notes
// R01: Mode 1: link indicator on while link is good, off otherwise.
// R02: Modes 2 and 3: link indicator on with link, blinks on activity.
// R03: Speed indicator on at 100 Mb/s, off at 10 Mb/s, every mode.
// R04: Mode 1: activity/collision indicator on during transmit or receive activity.
// R05: Mode 2: activity/collision indicator shows collision by default.
// R06: Mode 3: a setting picks collision or full duplex for that indicator.
// R07: Activity is stretched into a visible blink of fixed period.
module pls_led_driver #(
  parameter int unsigned BLINK_CYCLES = `PLS_BLINK_CYCLES
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transceiver core status
  input wire logic link_good,
  input wire logic speed_100,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic collision,
  input wire logic full_duplex,
  // Indicator outputs, high means on
  output logic link_indicator,
  output logic speed_indicator,
  output logic activity_collision_indicator
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [5:0] s1_q, s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
    end else begin
      s1_q <= {full_duplex, collision, rx_active, tx_active, speed_100, link_good};
      s2_q <= s1_q;
    end
  end
  logic lnk, spd, act, col, fdx;
  assign lnk = s2_q[0];
  assign spd = s2_q[1];
  assign act = s2_q[2] | s2_q[3];
  assign col = s2_q[4];
  assign fdx = s2_q[5];

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [2:0] led_q, led_d;
  logic setup;
  assign setup = psel && !penable;

  // Address match used only for the slverr decode of reads and writes
  function automatic logic is_mapped(input logic [11:0] a);
    return (a == `PLS_OFF_CTRL) || (a == `PLS_OFF_STATUS);
  endfunction : is_mapped

  // APB: answer one cycle after setup, unmapped gives slverr
  always_comb begin
    ctrl_d = ctrl_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (setup) begin
      pready_d = 1'b1;
      pslverr_d = !is_mapped(paddr);
      prdata_d = 32'h0000_0000;
      if (!pwrite) begin
        if (paddr == `PLS_OFF_CTRL) begin
          prdata_d = ctrl_q;
        end else if (paddr == `PLS_OFF_STATUS) begin
          prdata_d = {24'h00_0000, 2'b00, led_q, fdx, col, lnk};
        end
      end
    end
    if (psel && penable && pready_q && pwrite && paddr == `PLS_OFF_CTRL) begin
      ctrl_d = {27'h000_0000, pwdata[`PLS_CTRL_DUPSEL_BIT], 2'b00,
                pwdata[`PLS_CTRL_MODE_MSB:`PLS_CTRL_MODE_LSB]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity blinker
  logic blink_busy, blink_dark;
  pls_blinker #(.HALF_CYCLES(BLINK_CYCLES)) u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .act(act),
    .busy(blink_busy),
    .dark(blink_dark)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Indicator selection by mode
  pls_pkg::pls_mode_t mode;
  logic dup_sel;
  assign mode = pls_pkg::pls_mode_t'(ctrl_q[`PLS_CTRL_MODE_MSB:`PLS_CTRL_MODE_LSB]);
  assign dup_sel = ctrl_q[`PLS_CTRL_DUPSEL_BIT];

  always_comb begin
    led_d[1] = spd; // [R03]
    case (mode)
      pls_pkg::PLS_MODE_2: begin
        led_d[0] = lnk && !blink_dark; // [R02] [R07]
        led_d[2] = col; // [R05]
      end
      pls_pkg::PLS_MODE_3: begin
        led_d[0] = lnk && !blink_dark; // [R02] [R07]
        led_d[2] = dup_sel ? fdx : col; // [R06]
      end
      default: begin
        led_d[0] = lnk; // [R01]
        led_d[2] = act || blink_busy; // [R04] [R07]
      end
    endcase
  end

  // Register state and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PLS_CTRL_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      led_q <= 3'h0;
    end else begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      led_q <= led_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign link_indicator = led_q[0];
  assign speed_indicator = led_q[1];
  assign activity_collision_indicator = led_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  logic m1, m2, m3;
  assign m1 = (mode != pls_pkg::PLS_MODE_2) && (mode != pls_pkg::PLS_MODE_3);
  assign m2 = mode == pls_pkg::PLS_MODE_2;
  assign m3 = mode == pls_pkg::PLS_MODE_3;

  sequence seq_mode_stable;
    $stable(ctrl_q);
  endsequence

  AST_M1_LINK: assert property (@(posedge pclk) disable iff (!presetn)
    (m1 and seq_mode_stable) |=> link_indicator == $past(lnk)) // [R01]
    else $error("mode 1 link indicator wrong");
  AST_M23_LINK_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (m2 || m3) && !lnk |=> !link_indicator) // [R02]
    else $error("link indicator on without link");
  AST_M23_BLINK: assert property (@(posedge pclk) disable iff (!presetn)
    (m2 || m3) && lnk && blink_dark |=> !link_indicator) // [R02]
    else $error("link indicator not dark during blink");
  AST_SPEED: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 speed_indicator == $past(spd)) // [R03]
    else $error("speed indicator wrong");
  AST_M1_ACT: assert property (@(posedge pclk) disable iff (!presetn)
    m1 && act |=> activity_collision_indicator) // [R04]
    else $error("activity not shown in mode 1");
  AST_M2_COL: assert property (@(posedge pclk) disable iff (!presetn)
    m2 |=> activity_collision_indicator == $past(col)) // [R05]
    else $error("collision not shown in mode 2");
  AST_M3_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    m3 |=> activity_collision_indicator == ($past(dup_sel) ? $past(fdx) : $past(col))) // [R06]
    else $error("mode 3 duplex/collision select wrong");
  AST_STRETCH: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(blink_busy) |-> blink_busy [*2]) // [R07]
    else $error("activity blink too short");
  AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("apb answer late");
endmodule : pls_led_driver
`default_nettype wire

// ==== tb/pls_led_model.sv ====
// Board LED model: counts the visible blinks of the link LED
`timescale 1ns/100ps
`default_nettype none
module pls_led_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // LED drive, high lights the LED
  input wire logic link_indicator,
  // Observed blink count
  output logic [7:0] link_blinks
);
  logic link_q;
  logic [7:0] blinks_q;
  logic [7:0] blinks_d;
  // One count per on-to-off change
  always_comb begin
    blinks_d = blinks_q + ((link_q && !link_indicator) ? 8'h01 : 8'h00);
  end
  // LED state and counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_q <= 1'b0;
      blinks_q <= 8'h00;
    end else begin
      link_q <= link_indicator;
      blinks_q <= blinks_d;
    end
  end
  assign link_blinks = blinks_q;
endmodule : pls_led_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench for the LED status driver
`timescale 1ns/100ps
`default_nettype none
`include "pls_defs.svh"
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err;
  logic link_good = 1'b0, speed_100 = 1'b0, tx_active = 1'b0;
  logic rx_active = 1'b0, collision = 1'b0, full_duplex = 1'b0;
  logic link_indicator, speed_indicator, activity_collision_indicator;
  logic [7:0] blinks, b0;
  int num_errors = 0, compares = 0, cycles = 0;
  // Clock, 4 ns period
  always #2 pclk = ~pclk;
  pls_led_driver #(.BLINK_CYCLES(4)) pls_led_driver_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_good(link_good), .speed_100(speed_100), .tx_active(tx_active),
    .rx_active(rx_active), .collision(collision), .full_duplex(full_duplex),
    .link_indicator(link_indicator), .speed_indicator(speed_indicator),
    .activity_collision_indicator(activity_collision_indicator));
  pls_led_model pls_led_model_i (.pclk(pclk), .presetn(presetn), .link_indicator(link_indicator),
    .link_blinks(blinks));
  ////////////////////////////////////////////////////////////////
  // Compare and report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Verdict and end of run
  task summarize;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // One APB transfer, waits for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait ends when pready is high; the hang guard ends the run if it never rises
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Set core status {link,speed,tx,rx,col,dup} and let it settle
  task sin(input logic [5:0] v);
    @(posedge pclk);
    {link_good, speed_100, tx_active, rx_active, collision, full_duplex} <= v;
    repeat (8) @(posedge pclk);
  endtask : sin
  // Indicators as {act/col, speed, link}
  task leds(input logic [2:0] e);
    chk({29'h0, activity_collision_indicator, speed_indicator, link_indicator}, {29'h0, e});
  endtask : leds
  ////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      summarize;
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `PLS_OFF_CTRL, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b1, 12'h008, 32'h0000_0003);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, `PLS_OFF_CTRL, 32'h0);
    chk(rd, 32'h0000_0001);
    sin(6'b110000);
    leds(3'b011);
    apb(1'b0, `PLS_OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_0019);
    sin(6'b111000);
    leds(3'b111);
    sin(6'b100100);
    leds(3'b101);
    sin(6'b100000);
    leds(3'b001);
    // One-cycle burst from idle, the LED must outlast it
    @(posedge pclk);
    rx_active <= 1'b1;
    @(posedge pclk);
    rx_active <= 1'b0;
    repeat (5) @(posedge pclk);
    leds(3'b101);
    repeat (20) @(posedge pclk);
    leds(3'b001);
    apb(1'b1, `PLS_OFF_CTRL, 32'hffff_fff2);
    apb(1'b0, `PLS_OFF_CTRL, 32'h0);
    chk(rd, 32'h0000_0012);
    sin(6'b100010);
    leds(3'b101);
    b0 = blinks;
    sin(6'b101000);
    sin(6'b100000);
    repeat (20) @(posedge pclk);
    chk({31'h0, blinks > b0}, 32'h1);
    leds(3'b001);
    apb(1'b1, `PLS_OFF_CTRL, 32'h0000_0013);
    sin(6'b100001);
    leds(3'b101);
    sin(6'b100010);
    leds(3'b001);
    apb(1'b1, `PLS_OFF_CTRL, 32'h0000_0003);
    repeat (4) @(posedge pclk);
    leds(3'b101);
    sin(6'b000010);
    leds(3'b100);
    // Mode code 0 falls back to mode 1 behaviour
    apb(1'b1, `PLS_OFF_CTRL, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    leds(3'b000);
    summarize;
  end
endmodule : tb_top
`default_nettype wire
